//--- core/fpis_regs.vh
// Constants for the front-panel input settings controller.
// Assumes a 100 MHz system clock and one includer per compile unit.
`ifndef FPIS_REGS_VH
`define FPIS_REGS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define FPIS_A_SEL     4'h0
`define FPIS_A_FULL_SCALE_SENSITIVITY    4'h1
`define FPIS_A_QF      4'h2
`define FPIS_A_FREQ    4'h3
`define FPIS_A_TRIM    4'h4
`define FPIS_A_DEPTH   4'h5
`define FPIS_A_STAT    4'h6
`define FPIS_A_MASK    4'h7

// ----------------------------------------
// Field positions and codes
// ----------------------------------------
`define FPIS_SEL_SRC_LO  0
`define FPIS_SEL_CPL     2
`define FPIS_SEL_GND     3
`define FPIS_SEL_TYP_LO  4
`define FPIS_SEL_FOC_LO  7
`define FPIS_SRC_LAST    2'h3
`define FPIS_TYP_LAST    3'h4
`define FPIS_FOC_LAST    2'h2
`define FPIS_FOC_TUNE    2'h0
`define FPIS_FOC_TRIM    2'h1
`define FPIS_FOC_DEPTH   2'h2
// Sensitivity index 0 is 100 nV, 21 is 500 mV
`define FPIS_FULL_SCALE_SENSITIVITY_MAX    5'h15
`define FPIS_FULL_SCALE_SENSITIVITY_RST    5'h15
`define FPIS_Q_MIN       7'h01
`define FPIS_Q_MAX       7'h64
`define FPIS_Q_RST       7'h01
// Frequency in Hz; kHz shown from 1000 Hz
`define FPIS_FREQ_MIN    17'h00001
`define FPIS_FREQ_MAX    17'h186a0
`define FPIS_FREQ_RST    17'h003e8
`define FPIS_FREQ_KHZ    17'h003e8
`define FPIS_TRIM_RST    8'h00
`define FPIS_DEPTH_RST   8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define FPIS_CLK_MHZ       100
`define FPIS_DEB_US        5000
`define FPIS_DEB_CYC       (`FPIS_DEB_US * `FPIS_CLK_MHZ)
`define FPIS_HOLD_MS       3000
`define FPIS_HOLD_CYC      (`FPIS_HOLD_MS * 1000 * `FPIS_CLK_MHZ)
`define FPIS_FAST_MS       50
`define FPIS_FAST_CYC      (`FPIS_FAST_MS * 1000 * `FPIS_CLK_MHZ)

`endif

//--- core/fpis_ctrl.v
// Front-panel input settings controller: buttons, knobs, lamps.
// Assumes raw panel pins, quadrature knobs, one 100 MHz clock.
`include "fpis_regs.vh"
`timescale 1ns/100ps
`default_nettype none
module fpis_ctrl #(
	parameter [31:0] DEB_CYC  = `FPIS_DEB_CYC,
	parameter [31:0] HOLD_CYC = `FPIS_HOLD_CYC,
	parameter [31:0] FAST_CYC = `FPIS_FAST_CYC
) (
	input  wire        clk_sys_i,
	input  wire        rst_b_i,
	input  wire        clk_en_i,
	input  wire        inhibit_up_i,
	input  wire        btn_source_i,
	input  wire        btn_couple_i,
	input  wire        btn_ground_i,
	input  wire        btn_type_i,
	input  wire        knob_push_i,
	input  wire [1:0]  knob_freq_ab_i,
	input  wire [1:0]  knob_full_scale_sensitivity_ab_i,
	input  wire [1:0]  knob_q_ab_i,
	input  wire        ovl_preamp_i,
	input  wire        ovl_acpath_i,
	input  wire [3:0]  addr_i,
	input  wire [31:0] wdata_i,
	input  wire        wr_i,
	input  wire        rd_i,
	output reg  [31:0] rdata_o,
	output reg  [1:0]  input_source_select_o,
	output reg         input_coupling_select_o,
	output reg         shield_ground_select_o,
	output reg  [4:0]  full_scale_sensitivity_o,
	output reg  [2:0]  input_filter_type_o,
	output reg  [6:0]  filter_quality_factor_o,
	output reg  [16:0] filter_tuning_frequency_o,
	output reg  [7:0]  filter_trim_value_o,
	output reg  [7:0]  notch_depth_o,
	output reg  [1:0]  knob_focus_o,
	output reg         unit_hz_o,
	output reg         unit_khz_o,
	output reg         overload_indicator_input_o,
	output reg         overload_indicator_full_scale_sensitivity_o,
	output reg         irq_o
);

// ----------------------------------------
// Synchronisers
// ----------------------------------------
localparam NS = 13;
wire [NS-1:0] raw_pins = {ovl_acpath_i, ovl_preamp_i, knob_q_ab_i, knob_full_scale_sensitivity_ab_i,
	knob_freq_ab_i, knob_push_i, btn_type_i, btn_ground_i, btn_couple_i,
	btn_source_i};
reg [NS-1:0] meta_ff;
reg [NS-1:0] sync_ff;
always @(posedge clk_sys_i or negedge rst_b_i) begin
	if (!rst_b_i) begin
		meta_ff <= {NS{1'b0}};
		sync_ff <= {NS{1'b0}};
	end else if (clk_en_i) begin
		meta_ff <= raw_pins;
		sync_ff <= meta_ff;
	end
end
// Inhibit switch has its own pair; it gates settings only, not lamps
reg  inh_m_ff;
reg  inh_s_ff;
always @(posedge clk_sys_i or negedge rst_b_i) begin
	if (!rst_b_i) begin
		inh_m_ff <= 1'b0;
		inh_s_ff <= 1'b0;
	end else if (clk_en_i) begin
		inh_m_ff <= inhibit_up_i;
		inh_s_ff <= inh_m_ff;
	end
end
wire inhibit_up_i_s = inh_s_ff;

// ----------------------------------------
// Debounce for five push inputs
// ----------------------------------------
// Stable level only taken after a quiet window; bounces restart it
reg [4:0]  deb_ff;
reg [4:0]  deb_d_ff;
reg [31:0] deb_cnt_ff [0:4];
integer i;
always @(posedge clk_sys_i or negedge rst_b_i) begin
	if (!rst_b_i) begin
		deb_ff   <= 5'h00;
		deb_d_ff <= 5'h00;
		for (i = 0; i < 5; i = i + 1) begin
			deb_cnt_ff[i] <= 32'h0;
		end
	end else if (clk_en_i) begin
		deb_d_ff <= deb_ff;
		for (i = 0; i < 5; i = i + 1) begin
			if (sync_ff[i] == deb_ff[i]) begin
				deb_cnt_ff[i] <= 32'h0;
			end else if (deb_cnt_ff[i] >= DEB_CYC - 32'h1) begin
				deb_ff[i]     <= sync_ff[i];
				deb_cnt_ff[i] <= 32'h0;
			end else begin
				deb_cnt_ff[i] <= deb_cnt_ff[i] + 32'h1;
			end
		end
	end
end
// Pressed edge only, one pulse per press
wire [4:0] press = deb_ff & ~deb_d_ff;
wire [4:0] release_ev = ~deb_ff & deb_d_ff;

// ----------------------------------------
// Knob decoders
// ----------------------------------------
reg  [5:0] ab_d_ff;
wire [5:0] ab_now = sync_ff[10:5];
// One step per full detent: count on A rising only
function [1:0] fpis_step;
	input [1:0] now;
	input [1:0] old;
	begin
		fpis_step = 2'b00;
		if (now[0] && !old[0]) begin
			fpis_step = now[1] ? 2'b10 : 2'b01;
		end
	end
endfunction
// Knob step on an 8-bit value; wraps at both ends on purpose
function [7:0] fpis_nudge8;
	input [7:0] v;
	input [1:0] st;
	begin
		fpis_nudge8 = (st == 2'b01) ? v + 8'h01 : v - 8'h01;
	end
endfunction
// Cyclic advance, back to zero after the last code
function [2:0] fpis_wrap3;
	input [2:0] v;
	input [2:0] last;
	begin
		fpis_wrap3 = (v == last) ? 3'h0 : v + 3'h1;
	end
endfunction
wire [1:0] st_freq = fpis_step(ab_now[1:0], ab_d_ff[1:0]);
wire [1:0] st_full_scale_sensitivity = fpis_step(ab_now[3:2], ab_d_ff[3:2]);
wire [1:0] st_q    = fpis_step(ab_now[5:4], ab_d_ff[5:4]);

// ----------------------------------------
// Knob push timing
// ----------------------------------------
reg [31:0] hold_cnt_ff;
reg        held_ff;
reg [31:0] gap_cnt_ff;
wire short_push = release_ev[4] && !held_ff;
wire long_push  = deb_ff[4] && !held_ff && hold_cnt_ff >= HOLD_CYC - 32'h1;
always @(posedge clk_sys_i or negedge rst_b_i) begin
	if (!rst_b_i) begin
		ab_d_ff     <= 6'h00;
		hold_cnt_ff <= 32'h0;
		held_ff     <= 1'b0;
		gap_cnt_ff  <= 32'h0;
	end else if (clk_en_i) begin
		ab_d_ff <= ab_now;
		if (!deb_ff[4]) begin
			hold_cnt_ff <= 32'h0;
			held_ff     <= 1'b0;
		end else if (long_push) begin
			held_ff <= 1'b1;
		end else if (!held_ff) begin
			hold_cnt_ff <= hold_cnt_ff + 32'h1;
		end
		if (st_freq != 2'b00) begin
			gap_cnt_ff <= 32'h0;
		end else if (gap_cnt_ff != 32'hffffffff) begin
			gap_cnt_ff <= gap_cnt_ff + 32'h1;
		end
	end
end
// Fast turning steps 10 below 1000 Hz, 100 below 10000 Hz, else 1000; slow turning steps 1
wire        fast  = gap_cnt_ff < FAST_CYC;
wire [16:0] fstep = fast ? (filter_tuning_frequency_o >= 17'd10000 ? 17'd1000 :
	filter_tuning_frequency_o >= 17'd1000 ? 17'd100 : 17'd10) : 17'd1;

// ----------------------------------------
// Settings
// ----------------------------------------
wire [16:0] f_up = (`FPIS_FREQ_MAX - filter_tuning_frequency_o < fstep) ?
	`FPIS_FREQ_MAX : filter_tuning_frequency_o + fstep;
wire [16:0] f_dn = (filter_tuning_frequency_o - `FPIS_FREQ_MIN < fstep) ?
	`FPIS_FREQ_MIN : filter_tuning_frequency_o - fstep;
// Settings writes share the inhibit gate; status and mask do not
wire wr_sel   = wr_i && addr_i == `FPIS_A_SEL;
wire wr_full_scale_sensitivity  = wr_i && addr_i == `FPIS_A_FULL_SCALE_SENSITIVITY;
wire wr_qf    = wr_i && addr_i == `FPIS_A_QF;
wire wr_freq  = wr_i && addr_i == `FPIS_A_FREQ;
wire wr_trim  = wr_i && addr_i == `FPIS_A_TRIM;
wire wr_depth = wr_i && addr_i == `FPIS_A_DEPTH;
wire wr_stat  = wr_i && addr_i == `FPIS_A_STAT;
wire wr_mask  = wr_i && addr_i == `FPIS_A_MASK;
wire [2:0] foc_nx = fpis_wrap3({1'b0, knob_focus_o}, {1'b0, `FPIS_FOC_LAST});
always @(posedge clk_sys_i or negedge rst_b_i) begin
	if (!rst_b_i) begin
		input_source_select_o     <= 2'h0;
		input_coupling_select_o   <= 1'b0;
		shield_ground_select_o    <= 1'b0;
		input_filter_type_o       <= 3'h0;
		knob_focus_o              <= `FPIS_FOC_TUNE;
		full_scale_sensitivity_o  <= `FPIS_FULL_SCALE_SENSITIVITY_RST;
		filter_quality_factor_o   <= `FPIS_Q_RST;
		filter_tuning_frequency_o <= `FPIS_FREQ_RST;
		filter_trim_value_o       <= `FPIS_TRIM_RST;
		notch_depth_o             <= `FPIS_DEPTH_RST;
	end else if (clk_en_i && !inhibit_up_i_s) begin
		if (press[0]) begin
			input_source_select_o <= input_source_select_o + 2'h1;
		end
		if (press[1]) begin
			input_coupling_select_o <= ~input_coupling_select_o;
		end
		if (press[2]) begin
			shield_ground_select_o <= ~shield_ground_select_o;
		end
		if (press[3]) begin
			input_filter_type_o <= fpis_wrap3(input_filter_type_o, `FPIS_TYP_LAST);
		end
		if (short_push) begin
			knob_focus_o <= foc_nx[1:0];
		end
		if (st_full_scale_sensitivity == 2'b01 && full_scale_sensitivity_o != `FPIS_FULL_SCALE_SENSITIVITY_MAX) begin
			full_scale_sensitivity_o <= full_scale_sensitivity_o + 5'h1;
		end else if (st_full_scale_sensitivity == 2'b10 && full_scale_sensitivity_o != 5'h00) begin
			full_scale_sensitivity_o <= full_scale_sensitivity_o - 5'h1;
		end
		if (st_q == 2'b01 && filter_quality_factor_o != `FPIS_Q_MAX) begin
			filter_quality_factor_o <= filter_quality_factor_o + 7'h1;
		end else if (st_q == 2'b10 && filter_quality_factor_o != `FPIS_Q_MIN) begin
			filter_quality_factor_o <= filter_quality_factor_o - 7'h1;
		end
		if (long_push) begin
			case (knob_focus_o)
			`FPIS_FOC_TRIM:  filter_trim_value_o <= `FPIS_TRIM_RST;
			`FPIS_FOC_DEPTH: notch_depth_o <= `FPIS_DEPTH_RST;
			default:         filter_tuning_frequency_o <= `FPIS_FREQ_RST;
			endcase
		end else if (st_freq != 2'b00) begin
			case (knob_focus_o)
			`FPIS_FOC_TRIM:  filter_trim_value_o <= fpis_nudge8(filter_trim_value_o, st_freq);
			`FPIS_FOC_DEPTH: notch_depth_o <= fpis_nudge8(notch_depth_o, st_freq);
			default:         filter_tuning_frequency_o <=
				(st_freq == 2'b01) ? f_up : f_dn;
			endcase
		end
		if (wr_sel) begin
			input_source_select_o   <= wdata_i[1:0];
			input_coupling_select_o <= wdata_i[`FPIS_SEL_CPL];
			shield_ground_select_o  <= wdata_i[`FPIS_SEL_GND];
			if (wdata_i[6:4] <= `FPIS_TYP_LAST) begin
				input_filter_type_o <= wdata_i[6:4];
			end
		end
		if (wr_full_scale_sensitivity && wdata_i[4:0] <= `FPIS_FULL_SCALE_SENSITIVITY_MAX) begin
			full_scale_sensitivity_o <= wdata_i[4:0];
		end
		if (wr_qf && wdata_i[6:0] >= `FPIS_Q_MIN &&
			wdata_i[6:0] <= `FPIS_Q_MAX) begin
			filter_quality_factor_o <= wdata_i[6:0];
		end
		if (wr_freq && wdata_i[16:0] >= `FPIS_FREQ_MIN &&
			wdata_i[16:0] <= `FPIS_FREQ_MAX) begin
			filter_tuning_frequency_o <= wdata_i[16:0];
		end
		if (wr_trim) begin
			filter_trim_value_o <= wdata_i[7:0];
		end
		if (wr_depth) begin
			notch_depth_o <= wdata_i[7:0];
		end
	end
end

// ----------------------------------------
// Lamps: overload and unit indicators
// ----------------------------------------
reg [1:0] stat_ff;
reg [1:0] mask_ff;
wire [1:0] ev = {sync_ff[12], sync_ff[11]};
wire show_f = (knob_focus_o == `FPIS_FOC_TUNE);
// Overload lamps follow the pins, unit lamps the focus and frequency, even while inhibited
always @(posedge clk_sys_i or negedge rst_b_i) begin
	if (!rst_b_i) begin
		unit_hz_o                  <= 1'b0;
		unit_khz_o                 <= 1'b0;
		overload_indicator_input_o <= 1'b0;
		overload_indicator_full_scale_sensitivity_o  <= 1'b0;
	end else if (clk_en_i) begin
		overload_indicator_input_o <= sync_ff[11];
		overload_indicator_full_scale_sensitivity_o  <= sync_ff[12];
		unit_khz_o <= show_f && filter_tuning_frequency_o >= `FPIS_FREQ_KHZ;
		unit_hz_o  <= show_f && filter_tuning_frequency_o < `FPIS_FREQ_KHZ;
	end
end

// ----------------------------------------
// Status, interrupt, read back
// ----------------------------------------
always @(posedge clk_sys_i or negedge rst_b_i) begin
	if (!rst_b_i) begin
		stat_ff                    <= 2'h0;
		mask_ff                    <= 2'h0;
		irq_o                      <= 1'b0;
		rdata_o                    <= 32'h0;
	end else if (clk_en_i) begin
		// Set wins over a write-one clear in the same cycle
		stat_ff <= (stat_ff & ~(wr_stat ? wdata_i[1:0] : 2'h0)) | ev;
		if (wr_mask) begin
			mask_ff <= wdata_i[1:0];
		end
		irq_o <= |(stat_ff & mask_ff);
		rdata_o <= 32'h0;
		if (rd_i) begin
			case (addr_i)
			`FPIS_A_SEL:   rdata_o <= {23'h0, knob_focus_o, input_filter_type_o,
				shield_ground_select_o, input_coupling_select_o, input_source_select_o};
			`FPIS_A_FULL_SCALE_SENSITIVITY:  rdata_o <= {27'h0, full_scale_sensitivity_o};
			`FPIS_A_QF:    rdata_o <= {25'h0, filter_quality_factor_o};
			`FPIS_A_FREQ:  rdata_o <= {15'h0, filter_tuning_frequency_o};
			`FPIS_A_TRIM:  rdata_o <= {24'h0, filter_trim_value_o};
			`FPIS_A_DEPTH: rdata_o <= {24'h0, notch_depth_o};
			`FPIS_A_STAT:  rdata_o <= {30'h0, stat_ff};
			`FPIS_A_MASK:  rdata_o <= {30'h0, mask_ff};
			default:       rdata_o <= 32'h0;
			endcase
		end
	end
end

endmodule
`default_nettype wire

//--- bench/fpis_checker.sv
// Concurrent checks on the settings controller outputs.
// Assumes binding to fpis_ctrl; cycles with clk_en_i low are skipped.
`timescale 1ns/100ps
`default_nettype none
module fpis_checker (
	input wire logic        clk_sys_i,
	input wire logic        rst_b_i,
	input wire logic        clk_en_i,
	input wire logic        inhibit_up_i,
	input wire logic        ovl_preamp_i,
	input wire logic        ovl_acpath_i,
	input wire logic        wr_i,
	input wire logic        rd_i,
	input wire logic [31:0] rdata_o,
	input wire logic [1:0]  input_source_select_o,
	input wire logic        input_coupling_select_o,
	input wire logic        shield_ground_select_o,
	input wire logic [4:0]  full_scale_sensitivity_o,
	input wire logic [2:0]  input_filter_type_o,
	input wire logic [6:0]  filter_quality_factor_o,
	input wire logic [16:0] filter_tuning_frequency_o,
	input wire logic [1:0]  knob_focus_o,
	input wire logic        unit_hz_o,
	input wire logic        unit_khz_o,
	input wire logic        overload_indicator_input_o,
	input wire logic        overload_indicator_full_scale_sensitivity_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	// Frozen cycles are not judged
	default disable iff (!rst_b_i || !clk_en_i);
	// ----------------------------------------
	// Sequences
	// ----------------------------------------
	// Six cycles: covers the two-stage sync of the switch
	sequence inh_held; inhibit_up_i[*6]; endsequence
	sequence pre_held; ovl_preamp_i[*4]; endsequence
	sequence ac_held; ovl_acpath_i[*4]; endsequence
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	inh_freeze_a: assert property (inh_held |=>
		$stable(input_source_select_o) && $stable(input_coupling_select_o)
		&& $stable(shield_ground_select_o) && $stable(full_scale_sensitivity_o)
		&& $stable(input_filter_type_o) && $stable(filter_quality_factor_o)
		&& $stable(filter_tuning_frequency_o)) else $error("setting moved while inhibited");
	src_cycle_a: assert property ($changed(input_source_select_o) && !$past(wr_i) |->
		input_source_select_o == $past(input_source_select_o) + 2'h1)
		else $error("source skipped a position");
	type_cycle_a: assert property ($changed(input_filter_type_o) && !$past(wr_i) |->
		input_filter_type_o == ($past(input_filter_type_o) == 3'h4 ? 3'h0
		: $past(input_filter_type_o) + 3'h1)) else $error("filter type skipped");
	full_scale_sensitivity_step_a: assert property ($changed(full_scale_sensitivity_o) && !$past(wr_i) |->
		full_scale_sensitivity_o <= 5'h15 && (full_scale_sensitivity_o ==
		$past(full_scale_sensitivity_o) + 5'h1 || full_scale_sensitivity_o + 5'h1 ==
		$past(full_scale_sensitivity_o))) else $error("sensitivity step wrong");
	q_range_a: assert property (filter_quality_factor_o >= 7'h01
		&& filter_quality_factor_o <= 7'h64) else $error("quality factor out of range");
	ovl_input_a: assert property (pre_held |-> overload_indicator_input_o)
		else $error("input overload lamp dark");
	ovl_full_scale_sensitivity_a: assert property (ac_held |-> overload_indicator_full_scale_sensitivity_o)
		else $error("sensitivity overload lamp dark");
	unit_one_a: assert property (knob_focus_o == 2'h0 && $past(knob_focus_o) == 2'h0
		&& $past(rst_b_i, 2) && $stable(filter_tuning_frequency_o) |-> unit_hz_o != unit_khz_o
		&& unit_khz_o == (filter_tuning_frequency_o >= 17'h003e8)) else $error("unit lamps wrong");
	unit_dark_a: assert property (knob_focus_o != 2'h0 && $past(knob_focus_o) != 2'h0 |->
		!unit_hz_o && !unit_khz_o) else $error("unit lamp lit off tune focus");
	focus_cycle_a: assert property ($changed(knob_focus_o) |-> knob_focus_o ==
		($past(knob_focus_o) == 2'h2 ? 2'h0 : $past(knob_focus_o) + 2'h1))
		else $error("focus skipped");
	rdata_idle_a: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
		else $error("read data without read");
endmodule
bind fpis_ctrl fpis_checker chk_u (.clk_sys_i, .rst_b_i, .clk_en_i, .inhibit_up_i, .ovl_preamp_i,
	.ovl_acpath_i, .wr_i, .rd_i, .rdata_o, .input_source_select_o, .input_coupling_select_o,
	.shield_ground_select_o, .full_scale_sensitivity_o, .input_filter_type_o,
	.filter_quality_factor_o, .filter_tuning_frequency_o, .knob_focus_o, .unit_hz_o,
	.unit_khz_o, .overload_indicator_input_o, .overload_indicator_full_scale_sensitivity_o);
`default_nettype wire

//--- bench/fpis_operator.sv
// Operator model: bouncing buttons, knob push, quadrature knobs.
// Assumes the bench calls its tasks one at a time.
`timescale 1ns/100ps
`default_nettype none
module fpis_operator (
	input wire logic      clk_i,
	output var logic [3:0] btn_o,
	output var logic       push_o,
	output var logic [1:0] freq_ab_o,
	output var logic [1:0] full_scale_sensitivity_ab_o,
	output var logic [1:0] q_ab_o
);
	initial begin
		btn_o = 4'h0;
		push_o = 1'b0;
		freq_ab_o = 2'h0;
		full_scale_sensitivity_ab_o = 2'h0;
		q_ab_o = 2'h0;
	end
	// One bounce at contact, so debounce is exercised
	task automatic press(input int idx);
		@(posedge clk_i) btn_o[idx] <= 1'b1;
		@(posedge clk_i) btn_o[idx] <= 1'b0;
		@(posedge clk_i) btn_o[idx] <= 1'b1;
		repeat (10) @(posedge clk_i);
		btn_o[idx] <= 1'b0;
		repeat (14) @(posedge clk_i);
	endtask
	task automatic push(input int hold);
		@(posedge clk_i) push_o <= 1'b1;
		repeat (hold) @(posedge clk_i);
		push_o <= 1'b0;
		repeat (14) @(posedge clk_i);
	endtask
	// Up: A rises while B low; down: B leads
	task automatic turn(input int k, input bit up, input int n, input int g);
		logic [1:0] ph;
		for (int i = 0; i < n; i++) begin
			for (int j = 0; j < 4; j++) begin
				case (j)
					0: ph = up ? 2'h1 : 2'h2;
					1: ph = 2'h3;
					2: ph = up ? 2'h2 : 2'h1;
					default: ph = 2'h0;
				endcase
				@(posedge clk_i);
				if (k == 0) freq_ab_o <= ph;
				else if (k == 1) full_scale_sensitivity_ab_o <= ph;
				else q_ab_o <= ph;
				repeat (g - 1) @(posedge clk_i);
			end
		end
		repeat (12) @(posedge clk_i);
	endtask
endmodule
`default_nettype wire

//--- bench/front_panel_input_settings_bench.sv
// Self-checking bench for the front-panel settings controller.
// Assumes short debounce, hold and speed counts via parameters.
`timescale 1ns/100ps
`default_nettype none
module front_panel_input_settings_bench;
	logic clk_sys_i = 1'b0, rst_b_i = 1'b0, inhibit_up_i = 1'b0;
	logic ovl_preamp_i = 1'b0, ovl_acpath_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
	logic [3:0] addr_i = 4'h0, btn;
	logic [31:0] wdata_i = 32'h0, rdata_o, rv;
	logic push, clk_en = 1'b1;
	logic [7:0] trm, dep;
	logic [1:0] kf, ks, kq, src, foc;
	logic cpl, gnd, hz, khz, lin, lsn, irq;
	logic [4:0] full_scale_sensitivity;
	logic [2:0] typ;
	logic [6:0] qf;
	logic [16:0] freq;
	int err_total = 0, total_checks = 0, n;
	int exp_sel[4] = '{0, 0, 0, 0};
	int last[4] = '{3, 1, 1, 4};
	initial forever #5 clk_sys_i = ~clk_sys_i;
	fpis_operator op_u (.clk_i(clk_sys_i), .btn_o(btn), .push_o(push), .freq_ab_o(kf),
		.full_scale_sensitivity_ab_o(ks), .q_ab_o(kq));
	fpis_ctrl #(.DEB_CYC(32'd4), .HOLD_CYC(32'd50), .FAST_CYC(32'd20)) dut_u (
		.clk_sys_i, .rst_b_i, .clk_en_i(clk_en), .inhibit_up_i, .btn_source_i(btn[0]),
		.btn_couple_i(btn[1]), .btn_ground_i(btn[2]), .btn_type_i(btn[3]), .knob_push_i(push),
		.knob_freq_ab_i(kf), .knob_full_scale_sensitivity_ab_i(ks), .knob_q_ab_i(kq), .ovl_preamp_i, .ovl_acpath_i,
		.addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .input_source_select_o(src),
		.input_coupling_select_o(cpl), .shield_ground_select_o(gnd),
		.full_scale_sensitivity_o(full_scale_sensitivity), .input_filter_type_o(typ),
		.filter_quality_factor_o(qf), .filter_tuning_frequency_o(freq),
		.filter_trim_value_o(trm), .notch_depth_o(dep), .knob_focus_o(foc), .unit_hz_o(hz),
		.unit_khz_o(khz), .overload_indicator_input_o(lin), .overload_indicator_full_scale_sensitivity_o(lsn),
		.irq_o(irq));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic int step_cyc(input int v, input int top);
		return (v == top) ? 0 : v + 1;
	endfunction
	function automatic logic [31:0] sel_of(input int b);
		return (b == 0) ? 32'(src) : (b == 1) ? 32'(cpl) : (b == 2) ? 32'(gnd) : 32'(typ);
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys_i) {wr_i, addr_i, wdata_i} <= {1'b1, a, d};
		@(posedge clk_sys_i) wr_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge clk_sys_i) {rd_i, addr_i} <= {1'b1, a};
		@(posedge clk_sys_i) rd_i <= 1'b0;
		#1 rv = rdata_o;
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// Bounded run: a hang counts as a mismatch
	initial begin
		repeat (60000) @(posedge clk_sys_i);
		err_total++;
		tally_and_finish();
	end
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		void'($urandom(32'h6a4af5ef));
		repeat (16) @(posedge clk_sys_i);
		rst_b_i <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		#1 chk({full_scale_sensitivity, qf, freq, khz}, {5'h15, 7'h01, 17'h003e8, 1'b1});
		for (int b = 0; b < 4; b++) begin
			n = 1 + $urandom % 6;
			repeat (n) begin
				op_u.press(b);
				exp_sel[b] = step_cyc(exp_sel[b], last[b]);
				chk(sel_of(b), 32'(exp_sel[b]));
			end
		end
		op_u.turn(1, 0, 25, 3);
		chk(32'(full_scale_sensitivity), 32'h0);
		op_u.turn(1, 1, 2, 3);
		chk(32'(full_scale_sensitivity), 32'h2);
		op_u.turn(2, 0, 2, 3);
		n = 1 + $urandom % 5;
		op_u.turn(2, 1, n, 3);
		chk(32'(qf), 32'(1 + n));
		op_u.turn(2, 1, 110, 3);
		chk(32'(qf), 32'h64);
		op_u.turn(0, 1, 1, 10);
		chk(32'(freq), 32'h3e9);
		op_u.turn(0, 1, 4, 2);
		chk(32'(freq > 17'h003f2), 32'h1);
		chk({hz, khz}, 2'h1);
		for (int f = 1; f < 4; f++) begin
			op_u.push(8);
			chk({foc, hz | khz}, {2'(f % 3), f % 3 != 0 ? 1'b0 : 1'b1});
			if (f == 1) begin
				op_u.turn(0, 1, 3, 3);
				chk(32'(trm), 32'h3);
				op_u.push(70);
				chk({foc, trm}, {2'h1, 8'h00});
			end
			if (f == 2) begin
				op_u.turn(0, 0, 2, 3);
				chk(32'(dep), 32'hfe);
			end
		end
		op_u.push(70);
		chk({foc, freq}, {2'h0, 17'h003e8});
		wr(4'h7, 32'h3);
		{ovl_preamp_i, ovl_acpath_i} <= 2'h3;
		repeat (6) @(posedge clk_sys_i);
		#1 chk({lin, lsn, irq}, 3'h7);
		wr(4'h6, 32'h3);
		chk(32'(irq), 32'h1);
		{ovl_preamp_i, ovl_acpath_i} <= 2'h0;
		repeat (4) @(posedge clk_sys_i);
		wr(4'h6, 32'h3);
		chk({lin, lsn, irq}, 3'h0);
		wr(4'h7, 32'h0);
		ovl_preamp_i <= 1'b1;
		repeat (5) @(posedge clk_sys_i);
		ovl_preamp_i <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
		rd(4'h6);
		chk({rv, irq}, {32'h1, 1'b0});
		wr(4'h7, 32'h1);
		chk(32'(irq), 32'h1);
		wr(4'h6, 32'h1);
		chk(32'(irq), 32'h0);
		rd(4'h1);
		chk(rv, 32'h2);
		rd(4'h8);
		chk(rv, 32'h0);
		rd(4'h5);
		chk(rv, 32'hfe);
		wr(4'h1, 32'h16);
		chk(32'(full_scale_sensitivity), 32'h2);
		clk_en <= 1'b0;
		op_u.press(1);
		clk_en <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		chk(32'(cpl), 32'(exp_sel[1]));
		inhibit_up_i <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		op_u.press(0);
		wr(4'h1, 32'h5);
		op_u.turn(1, 1, 1, 3);
		chk({src, full_scale_sensitivity}, {2'(exp_sel[0]), 5'h2});
		inhibit_up_i <= 1'b0;
		tally_and_finish();
	end
endmodule
`default_nettype wire
